/* include/pfc_regs.svh */
// Functional notes
// - Occupancy above upper mark sends pause frame
// - After pause, resume once below lower mark
// - Pause resent while occupancy stays above upper
// - Refresh value 0..65535 slots, carried in frame
// - One slot equals 64 byte times
// - Refresh value defaults to 26624 slots
// - Thresholds 0..511 KB at 10G, 0..47 KB 1G
// - 10G defaults upper 128 KB, lower 64 KB
// - 1G defaults upper 24 KB, lower 16 KB
// - Disabled after reset, no frames until enabled
// - Only link-level pause frames, no priority control
// - Shared pool of 8000 buffers of 250 bytes
// - Pool usage above 8000 pauses every enabled port
// - Port usage above 1250 pauses that port
// - Resume below 5000 global and 1000 per port
// - Received pause frames never throttle our transmitter
// - Flow control config change resets interface, frames may drop
// - Pause only on data ports of 1G or faster
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

`define PFC_ADDR_CTRL 8'h00
`define PFC_ADDR_HIGH 8'h04
`define PFC_ADDR_LOW 8'h08
`define PFC_ADDR_REFRESH 8'h0C
`define PFC_ADDR_STATUS 8'h10
`define PFC_ADDR_COUNT 8'h14
`define PFC_ADDR_SA_LO 8'h18
`define PFC_ADDR_SA_HI 8'h1C

`define PFC_CTRL_EN_BIT 0
`define PFC_CTRL_SHARED_BIT 1

`define PFC_HIGH_10G_RST 9'h080
`define PFC_LOW_10G_RST 9'h040
`define PFC_HIGH_1G_RST 9'h018
`define PFC_LOW_1G_RST 9'h010
`define PFC_MAX_10G 9'h1FF
`define PFC_MAX_1G 9'h02F
`define PFC_REFRESH_RST 16'h6800
`define PFC_SA_RST 48'h02_00_00_00_00_01

`define PFC_POOL_BUFFERS 14'h1F40
`define PFC_BUFFER_BYTES 250
`define PFC_GLOBAL_HIGH 14'h1F40
`define PFC_GLOBAL_LOW 14'h1388
`define PFC_PORT_HIGH 14'h04E2
`define PFC_PORT_LOW 14'h03E8

`define PFC_CLK_PERIOD_NS 10
`define PFC_BITS_PER_NS_1G 1
`define PFC_BITS_PER_NS_10G 10
`define PFC_SLOT_BYTES 64
`define PFC_SLOT_BITS (`PFC_SLOT_BYTES * 8)
`define PFC_FRAME_LAST 6'h3B

`endif

/* include/pfc_pkg.sv */
package pfc_pkg;

	typedef enum logic [1:0] {
		PFC_IDLE = 2'b01,
		PFC_SEND = 2'b10
	} pfc_state_type;

	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
		logic valid;
	} pfc_stream_type;

	typedef struct packed {
		logic [19:0] fifo_bytes;
		logic [13:0] pool_used;
		logic [13:0] port_used;
	} pfc_occ_type;

endpackage : pfc_pkg

/* logic/pfc_tx.sv */
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "pfc_regs.svh"

module pfc_tx (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_10g,
	input wire logic port_capable,
	input wire pfc_pkg::pfc_occ_type occ,
	output pfc_pkg::pfc_stream_type tx_out,
	input wire logic tx_ready,
	output logic iface_rst,
	output logic pause_active
);
	import pfc_pkg::*;

	// Configuration registers
	logic enable_r;
	logic shared_r;
	logic [8:0] high_r;
	logic [8:0] low_r;
	logic high_prog_r;
	logic low_prog_r;
	logic [15:0] refresh_r;
	logic [47:0] sa_r;

	// Frame counters and bus answer
	logic [15:0] xoff_cnt_r;
	logic [15:0] xon_cnt_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// Interface reset, pause state and slot timing
	logic iface_rst_r;
	logic paused_r;
	logic [9:0] slot_acc_r;
	logic slot_tick_r;
	logic [15:0] slot_cnt_r;

	// Frame generator
	pfc_state_type state_r;
	logic [5:0] idx_r;
	logic [15:0] time_r;
	pfc_stream_type stream_r;

	// Decode and handshake terms
	logic setup;
	logic wr_done;
	logic cfg_write;
	logic [8:0] high_eff;
	logic [8:0] low_eff;
	logic above_high;
	logic below_low;
	logic active;
	logic want_xoff;
	logic want_xon;
	logic start;
	logic byte_taken;
	logic [9:0] rate;
	logic [10:0] acc_sum;

	// Writes that change flow control restart the interface
	function automatic logic is_cfg(input logic [7:0] a);
		is_cfg = a == `PFC_ADDR_CTRL || a == `PFC_ADDR_HIGH ||
			a == `PFC_ADDR_LOW || a == `PFC_ADDR_REFRESH;
	endfunction : is_cfg

	// Thresholds are whole kilobytes; compare in bytes
	function automatic logic [19:0] kb_bytes(input logic [8:0] kb);
		kb_bytes = {1'b0, kb, 10'h000};
	endfunction : kb_bytes

	// Read back clamped, so software sees what the compare uses
	function automatic logic [8:0] eff_thr(input logic prog,
		input logic [8:0] val, input logic [8:0] dflt,
		input logic [8:0] maxv);
		if (!prog) begin
			eff_thr = dflt;
		end else if (val > maxv) begin
			eff_thr = maxv;
		end else begin
			eff_thr = val;
		end
	endfunction : eff_thr

	function automatic logic [7:0] frame_byte(input logic [5:0] i,
		input logic [47:0] sa, input logic [15:0] t);
		case (i)
			// Reserved control multicast destination
			6'h00: frame_byte = 8'h01;
			6'h01: frame_byte = 8'h80;
			6'h02: frame_byte = 8'hC2;
			6'h03: frame_byte = 8'h00;
			6'h04: frame_byte = 8'h00;
			6'h05: frame_byte = 8'h01;
			// Source address, most significant byte first
			6'h06: frame_byte = sa[47:40];
			6'h07: frame_byte = sa[39:32];
			6'h08: frame_byte = sa[31:24];
			6'h09: frame_byte = sa[23:16];
			6'h0A: frame_byte = sa[15:8];
			6'h0B: frame_byte = sa[7:0];
			// Control type and pause opcode
			6'h0C: frame_byte = 8'h88;
			6'h0D: frame_byte = 8'h08;
			6'h0E: frame_byte = 8'h00;
			6'h0F: frame_byte = 8'h01;
			// Pause time, zero for a resume
			6'h10: frame_byte = t[15:8];
			6'h11: frame_byte = t[7:0];
			// Zero pad up to the minimum frame size
			default: frame_byte = 8'h00;
		endcase
	endfunction : frame_byte

	// Registered answer gives one access cycle with no wait states
	assign setup = psel && !penable;
	assign wr_done = psel && penable && pready_r && pwrite && !pslverr_r;
	assign cfg_write = wr_done && is_cfg(paddr);

	assign high_eff = link_10g ?
		eff_thr(high_prog_r, high_r, `PFC_HIGH_10G_RST, `PFC_MAX_10G) :
		eff_thr(high_prog_r, high_r, `PFC_HIGH_1G_RST, `PFC_MAX_1G);
	assign low_eff = link_10g ?
		eff_thr(low_prog_r, low_r, `PFC_LOW_10G_RST, `PFC_MAX_10G) :
		eff_thr(low_prog_r, low_r, `PFC_LOW_1G_RST, `PFC_MAX_1G);

	// Shared pool counts whole buffers of the fixed size
	always_comb begin
		if (shared_r) begin
			above_high = occ.pool_used > `PFC_GLOBAL_HIGH ||
				occ.port_used > `PFC_PORT_HIGH;
			below_low = occ.pool_used < `PFC_GLOBAL_LOW &&
				occ.port_used < `PFC_PORT_LOW;
		end else begin
			above_high = occ.fifo_bytes > kb_bytes(high_eff);
			below_low = occ.fifo_bytes < kb_bytes(low_eff);
		end
	end

	// Management or sub-gigabit ports never emit control frames
	assign active = enable_r && port_capable;
	// Refresh 0 gives back to back pauses while still congested
	assign want_xoff = active && above_high &&
		(!paused_r || slot_cnt_r >= refresh_r);
	assign want_xon = active && paused_r && below_low;
	assign start = state_r == PFC_IDLE && !iface_rst_r &&
		(want_xoff || want_xon);
	assign byte_taken = stream_r.valid && tx_ready;

	// Bits per cycle; the remainder carries so slot error never builds
	assign rate = link_10g ?
		10'(`PFC_CLK_PERIOD_NS * `PFC_BITS_PER_NS_10G) :
		10'(`PFC_CLK_PERIOD_NS * `PFC_BITS_PER_NS_1G);
	assign acc_sum = {1'b0, slot_acc_r} + {1'b0, rate};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			pready_r <= 1'b1;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			case (paddr)
				`PFC_ADDR_CTRL: prdata_r <= {30'h0, shared_r, enable_r};
				`PFC_ADDR_HIGH: prdata_r <= {23'h0, high_eff};
				`PFC_ADDR_LOW: prdata_r <= {23'h0, low_eff};
				`PFC_ADDR_REFRESH: prdata_r <= {16'h0, refresh_r};
				`PFC_ADDR_STATUS: prdata_r <= {28'h0, link_10g,
					above_high, stream_r.valid, paused_r};
				`PFC_ADDR_COUNT: prdata_r <= {xon_cnt_r, xoff_cnt_r};
				`PFC_ADDR_SA_LO: prdata_r <= sa_r[31:0];
				`PFC_ADDR_SA_HI: prdata_r <= {16'h0, sa_r[47:32]};
				// Unmapped offsets answer with an error and read zero
				default: pslverr_r <= 1'b1;
			endcase
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			enable_r <= 1'b0;
			shared_r <= 1'b0;
			high_r <= `PFC_HIGH_10G_RST;
			low_r <= `PFC_LOW_10G_RST;
			high_prog_r <= 1'b0;
			low_prog_r <= 1'b0;
			refresh_r <= `PFC_REFRESH_RST;
			sa_r <= `PFC_SA_RST;
		end else if (wr_done) begin
			case (paddr)
				`PFC_ADDR_CTRL: begin
					enable_r <= pwdata[`PFC_CTRL_EN_BIT];
					shared_r <= pwdata[`PFC_CTRL_SHARED_BIT];
				end
				`PFC_ADDR_HIGH: begin
					high_r <= pwdata[8:0];
					high_prog_r <= 1'b1;
				end
				`PFC_ADDR_LOW: begin
					low_r <= pwdata[8:0];
					low_prog_r <= 1'b1;
				end
				`PFC_ADDR_REFRESH: refresh_r <= pwdata[15:0];
				`PFC_ADDR_SA_LO: sa_r[31:0] <= pwdata;
				`PFC_ADDR_SA_HI: sa_r[47:32] <= pwdata[15:0];
				// Read-only offsets drop the write silently
				default: ;
			endcase
		end
	end

	// One-cycle interface reset on any flow control change
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			iface_rst_r <= 1'b0;
		end else begin
			iface_rst_r <= cfg_write;
		end
	end

	// Fractional accumulator: slot length is not a whole cycle count
	always_ff @(posedge ref_clk) begin
		if (sys_rst || iface_rst_r) begin
			slot_acc_r <= 10'h000;
			slot_tick_r <= 1'b0;
		end else if (acc_sum >= 11'(`PFC_SLOT_BITS)) begin
			slot_acc_r <= 10'(acc_sum - 11'(`PFC_SLOT_BITS));
			slot_tick_r <= 1'b1;
		end else begin
			slot_acc_r <= acc_sum[9:0];
			slot_tick_r <= 1'b0;
		end
	end

	// Saturates so a long pause never wraps into a false refresh
	always_ff @(posedge ref_clk) begin
		if (sys_rst || iface_rst_r) begin
			slot_cnt_r <= 16'h0000;
		end else if (start && want_xoff) begin
			slot_cnt_r <= 16'h0000;
		end else if (slot_tick_r && slot_cnt_r != 16'hFFFF) begin
			slot_cnt_r <= slot_cnt_r + 16'h0001;
		end
	end

	// Pause state follows frame starts; xoff wins over xon
	always_ff @(posedge ref_clk) begin
		if (sys_rst || iface_rst_r || !active) begin
			paused_r <= 1'b0;
		end else if (start && want_xoff) begin
			paused_r <= 1'b1;
		end else if (start && want_xon) begin
			paused_r <= 1'b0;
		end
	end

	// Receive path pause frames are not an input: nothing throttles us
	always_ff @(posedge ref_clk) begin
		if (sys_rst || iface_rst_r) begin
			state_r <= PFC_IDLE;
			idx_r <= 6'h00;
			time_r <= 16'h0000;
			stream_r <= '0;
		end else begin
			case (state_r)
				PFC_IDLE: begin
					if (start) begin
						state_r <= PFC_SEND;
						// Resume frame carries a zero timer
						time_r <= want_xoff ? refresh_r : 16'h0000;
						idx_r <= 6'h00;
						stream_r.data <= frame_byte(6'h00, sa_r, 16'h0000);
						stream_r.sof <= 1'b1;
						stream_r.eof <= 1'b0;
						stream_r.valid <= 1'b1;
					end
				end
				PFC_SEND: begin
					if (byte_taken) begin
						if (idx_r == `PFC_FRAME_LAST) begin
							state_r <= PFC_IDLE;
							stream_r <= '0;
						end else begin
							idx_r <= idx_r + 6'h01;
							stream_r.data <= frame_byte(idx_r + 6'h01, sa_r,
								time_r);
							stream_r.sof <= 1'b0;
							stream_r.eof <= (idx_r + 6'h01) == `PFC_FRAME_LAST;
						end
					end
				end
				// A corrupt one-hot code falls back to idle
				default: begin
					state_r <= PFC_IDLE;
					stream_r <= '0;
				end
			endcase
		end
	end

	// Counters wrap; software works with differences
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			xoff_cnt_r <= 16'h0000;
			xon_cnt_r <= 16'h0000;
		end else if (start) begin
			if (want_xoff) begin
				xoff_cnt_r <= xoff_cnt_r + 16'h0001;
			end else begin
				xon_cnt_r <= xon_cnt_r + 16'h0001;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_out = stream_r;
	assign iface_rst = iface_rst_r;
	assign pause_active = paused_r;

endmodule : pfc_tx

/* test/pfc_tx_asserts.sv */
`timescale 1ns/100ps
module pfc_tx_asserts (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic port_capable,
	input wire pfc_pkg::pfc_stream_type tx_out,
	input wire logic tx_ready,
	input wire logic iface_rst
);
	import pfc_pkg::*;
	logic [5:0] nb_r;
	logic take;
	assign take = tx_out.valid && tx_ready;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	sequence cfg_wr_s;
		psel && penable && pready && pwrite && !pslverr &&
			paddr <= 8'h0C && paddr[1:0] == 2'h0;
	endsequence
	sequence sof_s;
		take && tx_out.sof;
	endsequence
	// An abort starts the byte count over
	always_ff @(posedge ref_clk)
		if (sys_rst || iface_rst)
			nb_r <= 6'h00;
		else if (take)
			nb_r <= tx_out.sof ? 6'h01 : nb_r + 6'h01;
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("long pready");
	unmapped_err_a: assert property (pready && paddr > 8'h1C |-> pslverr)
		else $error("no slave error");
	cfg_reset_a: assert property (cfg_wr_s |=> iface_rst)
		else $error("no interface reset");
	reset_pulse_a: assert property (iface_rst |=> !iface_rst)
		else $error("long reset pulse");
	abort_frame_a: assert property (iface_rst |=> !tx_out.valid)
		else $error("frame kept");
	no_port_a: assert property (
		!port_capable && !tx_out.valid |=> !tx_out.valid)
		else $error("frame on bad port");
	sof_byte_a: assert property (sof_s |-> tx_out.data == 8'h01)
		else $error("bad first byte");
	byte_hold_a: assert property (tx_out.valid && !tx_ready |=>
		$stable(tx_out) || !tx_out.valid)
		else $error("byte changed");
	frame_len_a: assert property (take && tx_out.eof |->
		nb_r == 6'h3B && !tx_out.sof)
		else $error("bad length");
endmodule : pfc_tx_asserts

/* test/pfc_link_peer.sv */
`timescale 1ns/100ps
module pfc_link_peer (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pfc_pkg::pfc_stream_type tx_out,
	input wire logic slow,
	output logic tx_ready,
	output int n_frames,
	output int n_bad,
	output logic [15:0] last_time
);
	import pfc_pkg::*;
	logic [7:0] b [0:59];
	int idx;
	initial begin
		n_frames = 0;
		n_bad = 0;
		idx = 0;
	end
	// Slow peer stalls every other cycle
	always @(posedge ref_clk)
		tx_ready <= !sys_rst && (!slow || !tx_ready);
	// Peer counts pauses, keeps the last pause time and checks length, fixed header bytes and last pad byte
	always @(posedge ref_clk) begin
		if (tx_out.valid && tx_ready) begin
			idx = tx_out.sof ? 0 : idx + 1;
			if (idx < 60)
				b[idx] = tx_out.data;
			if (tx_out.eof) begin
				n_frames <= n_frames + 1;
				last_time <= {b[16], b[17]};
				if (idx != 59 || {b[0], b[1], b[2], b[3], b[4], b[5],
					b[12], b[13], b[14], b[15], b[59]} !==
					88'h0180C2000001_88080001_00)
					n_bad <= n_bad + 1;
			end
		end
	end
endmodule : pfc_link_peer

/* test/tb_pfc_tx.sv */
`timescale 1ns/100ps
module tb_pfc_tx;
	import pfc_pkg::*;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
	logic link_10g, port_capable, tx_ready, iface_rst, pause_active, slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] seed = 32'h57963189;
	logic [15:0] last_time;
	pfc_occ_type occ;
	pfc_stream_type tx_out;
	int fails = 0;
	int n_tests = 0;
	int n_frames, n_bad, n0, refr;
	pfc_tx dut_u (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link_10g, .port_capable,
		.occ, .tx_out, .tx_ready, .iface_rst, .pause_active);
	pfc_link_peer peer_u (.ref_clk, .sys_rst, .tx_out, .slow, .tx_ready,
		.n_frames, .n_bad, .last_time);
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = !ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic close_out;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do
			@(posedge ref_clk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		if (a == 8'h0C)
			refr = d[15:0];
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic ee);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
		chk({31'h0, er}, {31'h0, ee});
	endtask : rdc
	task automatic frame(input int e);
		n0 = n_frames;
		repeat (400) if (n_frames == n0) @(posedge ref_clk);
		chk(32'(n_frames - n0), 32'h1);
		chk({16'h0, last_time}, 32'(e));
		chk(32'(n_bad), 32'h0);
	endtask : frame
	task automatic quiet;
		repeat (3) @(posedge ref_clk);
		n0 = n_frames;
		repeat (150) @(posedge ref_clk);
		chk(32'(n_frames - n0), 32'h0);
	endtask : quiet
	task automatic do_reset(input logic g10);
		sys_rst <= 1'h1;
		link_10g <= g10;
		refr = 26624;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'h0;
		@(posedge ref_clk);
	endtask : do_reset
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, slow} = '0;
		occ = '0;
		port_capable = 1'h1;
		do_reset(1'h0);
		rdc(8'h04, 32'h18, 1'h0);
		rdc(8'h08, 32'h10, 1'h0);
		wr(8'h04, 32'h30);
		rdc(8'h04, 32'h2F, 1'h0);
		$display("one gig test done");
		do_reset(1'h1);
		rdc(8'h00, 32'h0, 1'h0);
		rdc(8'h04, 32'h80, 1'h0);
		rdc(8'h08, 32'h40, 1'h0);
		rdc(8'h0C, 32'h6800, 1'h0);
		rdc(8'h40, 32'h0, 1'h1);
		wr(8'h04, 32'h3FF);
		rdc(8'h04, 32'h1FF, 1'h0);
		$display("register test done");
		seed = xs(seed);
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h1);
		wr(8'h0C, {17'h1, seed[14:0]});
		wr(8'h00, 32'h1);
		slow <= 1'h1;
		occ.fifo_bytes <= 20'(2049 + seed[30:20]);
		frame(refr);
		chk({31'h0, pause_active}, 32'h1);
		occ.fifo_bytes <= 20'h00600;
		quiet();
		occ.fifo_bytes <= 20'h003FF;
		frame(0);
		rdc(8'h14, 32'h0001_0001, 1'h0);
		$display("fifo test done");
		slow <= 1'h0;
		wr(8'h0C, 32'h1);
		occ.fifo_bytes <= 20'h00C00;
		n0 = n_frames;
		repeat (400) @(posedge ref_clk);
		chk(32'(n_frames - n0 >= 3), 32'h1);
		chk({16'h0, last_time}, 32'h1);
		wr(8'h00, 32'h0);
		quiet();
		$display("refresh test done");
		wr(8'h0C, 32'hFFFF);
		wr(8'h00, 32'h3);
		occ <= '{20'h0, 14'h1F40, 14'h04E2};
		quiet();
		occ.pool_used <= 14'h1F41;
		frame(refr);
		occ <= '{20'h0, 14'h1387, 14'h03E7};
		frame(0);
		occ.port_used <= 14'h04E3;
		frame(refr);
		occ.port_used <= 14'h03E7;
		frame(0);
		port_capable <= 1'h0;
		occ.pool_used <= 14'h1F41;
		quiet();
		port_capable <= 1'h1;
		frame(refr);
		$display("shared test done");
		close_out();
	end
endmodule : tb_pfc_tx
bind pfc_tx pfc_tx_asserts chk_u (.ref_clk, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pready, .pslverr, .port_capable, .tx_out, .tx_ready,
	.iface_rst);
